// ===== hdl/bau_top.sv
/*
  Binary arithmetic unit: unsigned divide, double add, double subtract and
  signed multiplies on operand words, with flags, behind an AXI4-Lite slave.
  Assumes one clock, a synchronous active-low reset and a well-behaved
  AXI4-Lite master with at most one write and one read under way.
*/
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
// Contract
// - With execution condition false, results and flags stay unchanged.
// - Divide puts quotient in first result word, remainder in next.
// - Divide sets the fault flag when the divisor word is zero.
// - Bad indirect pointer (non-BCD or beyond area) sets the fault flag.
// - Divide sets zero flag on zero quotient; double add, double subtract on zero result.
// - Double add sums both word pairs and carry into the result pair.
// - Double add sets carry when the unsigned sum exceeds 32 bits.
// - Double subtract takes carry and deducted value from the base.
// - A negative difference sets carry and stores its two's complement.
// - Signed 16x16 multiply stores 32-bit product, low word first.
// - Signed 16x16 multiply sets zero only when the product is zero.
// - Signed 32x32 multiply stores 64-bit product over four words.
// - Signed 32x32 multiply sets zero only when all four words are zero.
`timescale 1ns/1ps
`include "bau_params.svh"

module bau_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Status
  output bau_pkg::bau_flags_s flags,
  output logic             irq
);

  logic                  aw_got;
  logic                  w_got;
  logic [7:0]            wr_addr;
  logic [31:0]           wr_data;
  logic [3:0]            wr_strb;
  logic                  wr_fire;
  logic [15:0]           opnd [4];
  logic [15:0]           res [4];
  logic [15:0]           next_res [4];
  logic [16:0]           ptr [3];
  logic [2:0]            ptr_bad;
  logic [2:0]            ctrl_op;
  logic                  ctrl_exec;
  bau_pkg::bau_state_e   state;
  bau_pkg::bau_flags_s   next_flags;
  logic [1:0]            int_stat;
  logic [1:0]            int_mask;
  logic [1:0]            int_evt;
  logic [1:0]            int_clr;
  logic                  start_req;
  logic                  div_go;
  logic                  div_done;
  logic [15:0]           div_quo;
  logic [15:0]           div_rem;
  logic [31:0]           a32;
  logic [31:0]           b32;
  logic [32:0]           add_u;
  logic [33:0]           add_s;
  logic [32:0]           sub_u;
  logic [33:0]           sub_s;
  logic signed [31:0]    mul16;
  logic signed [63:0]    mul32;
  logic [31:0]           rd_word;
  logic                  rd_ok;

  // Byte-lane merge of a write into a 32-bit image.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Offset is one of the mapped, word-aligned registers.
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) &&
           ((a == `BAU_OFS_CTRL) || (a == `BAU_OFS_FLAGS) ||
            ((a >= `BAU_OFS_OPND0) && (a <= `BAU_OFS_PTR2)) ||
            (a == `BAU_OFS_INT_STAT) || (a == `BAU_OFS_INT_MASK));
  endfunction : mapped

  // Write channel acceptance; address and data may arrive in any order.
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign wr_fire       = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      wr_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got  <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got   <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got   <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BAU_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(wr_addr) ? `BAU_RESP_OKAY : `BAU_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path: one cycle from address handshake to data.
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = mapped(s_axi_araddr);
    if (s_axi_araddr == `BAU_OFS_CTRL) begin
      rd_word[`BAU_CTRL_OP_MSB:`BAU_CTRL_OP_LSB] = ctrl_op;
      rd_word[`BAU_CTRL_EXEC] = ctrl_exec;
      rd_word[`BAU_CTRL_BUSY] = (state == bau_pkg::BAU_ST_DIV);
    end else if (s_axi_araddr == `BAU_OFS_FLAGS) begin
      rd_word[4:0] = flags;
    end else if ((s_axi_araddr >= `BAU_OFS_OPND0) &&
                 (s_axi_araddr <= `BAU_OFS_OPND3)) begin
      rd_word[15:0] = opnd[s_axi_araddr[3:2]];
    end else if ((s_axi_araddr >= `BAU_OFS_RES0) &&
                 (s_axi_araddr <= `BAU_OFS_RES3)) begin
      rd_word[15:0] = res[s_axi_araddr[3:2]];
    end else if ((s_axi_araddr >= `BAU_OFS_PTR0) &&
                 (s_axi_araddr <= `BAU_OFS_PTR2)) begin
      rd_word[16:0] = ptr[s_axi_araddr[3:2]];
    end else if (s_axi_araddr == `BAU_OFS_INT_STAT) begin
      rd_word[1:0] = int_stat;
    end else if (s_axi_araddr == `BAU_OFS_INT_MASK) begin
      rd_word[1:0] = int_mask;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `BAU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
      s_axi_rresp  <= rd_ok ? `BAU_RESP_OKAY : `BAU_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Software-written operand, pointer and control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        opnd[i] <= `BAU_RST_WORD;
      end
      for (int i = 0; i < 3; i++) begin
        ptr[i] <= `BAU_RST_PTR;
      end
      ctrl_op   <= 3'h0;
      ctrl_exec <= 1'b0;
      int_mask  <= `BAU_RST_INT;
    end else if (wr_fire) begin
      if ((wr_addr >= `BAU_OFS_OPND0) && (wr_addr <= `BAU_OFS_OPND3) &&
          (wr_addr[1:0] == 2'h0)) begin
        opnd[wr_addr[3:2]] <= 16'(merge({16'h0000, opnd[wr_addr[3:2]]},
                                        wr_data, wr_strb));
      end
      if ((wr_addr >= `BAU_OFS_PTR0) && (wr_addr <= `BAU_OFS_PTR2) &&
          (wr_addr[1:0] == 2'h0)) begin
        ptr[wr_addr[3:2]] <= 17'(merge({15'h0000, ptr[wr_addr[3:2]]},
                                       wr_data, wr_strb));
      end
      if ((wr_addr == `BAU_OFS_CTRL) && wr_strb[0]) begin
        ctrl_op   <= wr_data[`BAU_CTRL_OP_MSB:`BAU_CTRL_OP_LSB];
        ctrl_exec <= wr_data[`BAU_CTRL_EXEC];
      end
      if ((wr_addr == `BAU_OFS_INT_MASK) && wr_strb[0]) begin
        int_mask <= wr_data[1:0];
      end
    end
  end

  // One checker for each indirect pointer of the instruction.
  for (genvar g = 0; g < 3; g++) begin : g_ptr
    bau_ptr_check u_ptr (
      .ptr_value (ptr[g][15:0]),
      .indirect  (ptr[g][`BAU_PTR_INDIRECT]),
      .bad       (ptr_bad[g])
    );
  end

  bau_divider u_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start     (div_go),
    .dividend  (opnd[0]),
    .divisor   (opnd[2]),
    .done      (div_done),
    .quotient  (div_quo),
    .remainder (div_rem)
  );

  assign start_req = wr_fire && (wr_addr == `BAU_OFS_CTRL) && wr_strb[0] &&
                     wr_data[`BAU_CTRL_START] &&
                     (state == bau_pkg::BAU_ST_IDLE);

  // Arithmetic on the operand word pairs, high word in the odd index.
  assign a32   = {opnd[1], opnd[0]};
  assign b32   = {opnd[3], opnd[2]};
  assign add_u = {1'b0, a32} + {1'b0, b32} + {32'h0000_0000, flags.carry_flag};
  assign add_s = {{2{a32[31]}}, a32} + {{2{b32[31]}}, b32} +
                 {33'h0_0000_0000, flags.carry_flag};
  assign sub_u = {1'b0, a32} - {1'b0, b32} - {32'h0000_0000, flags.carry_flag};
  assign sub_s = {{2{a32[31]}}, a32} - {{2{b32[31]}}, b32} -
                 {33'h0_0000_0000, flags.carry_flag};
  assign mul16 = $signed(opnd[0]) * $signed(opnd[2]);
  assign mul32 = $signed(a32) * $signed(b32);

  always_comb begin
    next_res   = res;
    next_flags = flags;
    div_go     = 1'b0;
    int_evt    = 2'h0;
    if ((wr_addr == `BAU_OFS_FLAGS) && wr_fire && wr_strb[0]) begin
      next_flags.carry_flag = wr_data[`BAU_FLAG_CARRY];
    end
    if (div_done) begin
      next_res[0]          = div_quo;
      next_res[1]          = div_rem;
      next_flags.zero_flag = (div_quo == 16'h0000);
      int_evt[`BAU_INT_DONE] = 1'b1;
    end
    if (start_req && wr_data[`BAU_CTRL_EXEC]) begin
      int_evt[`BAU_INT_DONE] = 1'b1;
      next_flags.fault_flag  = 1'b0;
      if (|ptr_bad) begin
        next_flags.fault_flag   = 1'b1;
        int_evt[`BAU_INT_FAULT] = 1'b1;
      end else begin
        unique case (wr_data[`BAU_CTRL_OP_MSB:`BAU_CTRL_OP_LSB])
          bau_pkg::BAU_OP_DIV: begin
            if (opnd[2] == 16'h0000) begin
              next_flags.fault_flag   = 1'b1;
              int_evt[`BAU_INT_FAULT] = 1'b1;
            end else begin
              div_go                 = 1'b1;
              int_evt[`BAU_INT_DONE] = 1'b0;
            end
          end
          bau_pkg::BAU_OP_ADD: begin
            next_res[0] = add_u[15:0];
            next_res[1] = add_u[31:16];
            next_flags.carry_flag = add_u[32];
            next_flags.zero_flag  = (add_u[31:0] == 32'h0000_0000);
            next_flags.overflow_flag  = !add_s[33] && (add_s[32:31] != 2'h0);
            next_flags.underflow_flag = add_s[33] && (add_s[32:31] != 2'h3);
          end
          bau_pkg::BAU_OP_SUB: begin
            next_res[0] = sub_u[15:0];
            next_res[1] = sub_u[31:16];
            next_flags.carry_flag = sub_u[32];
            next_flags.zero_flag  = (sub_u[31:0] == 32'h0000_0000);
            next_flags.overflow_flag  = !sub_s[33] && (sub_s[32:31] != 2'h0);
            next_flags.underflow_flag = sub_s[33] && (sub_s[32:31] != 2'h3);
          end
          bau_pkg::BAU_OP_MUL16: begin
            next_res[0] = mul16[15:0];
            next_res[1] = mul16[31:16];
            next_flags.zero_flag = (mul16 == 32'sh0000_0000);
          end
          bau_pkg::BAU_OP_MUL32: begin
            for (int i = 0; i < 4; i++) begin
              next_res[i] = mul32[i*16 +: 16];
            end
            next_flags.zero_flag = (mul32 == 64'sh0000_0000_0000_0000);
          end
          default: begin
            int_evt[`BAU_INT_DONE] = 1'b0;
            next_flags.fault_flag  = flags.fault_flag;
          end
        endcase
      end
    end
  end

  // Result words and flags.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        res[i] <= `BAU_RST_WORD;
      end
      flags <= 5'h00;
    end else begin
      res   <= next_res;
      flags <= next_flags;
    end
  end

  // Sequencer: busy while the divider runs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= bau_pkg::BAU_ST_IDLE;
    end else begin
      unique case (state)
        bau_pkg::BAU_ST_IDLE: begin
          if (div_go) begin
            state <= bau_pkg::BAU_ST_DIV;
          end
        end
        bau_pkg::BAU_ST_DIV: begin
          if (div_done) begin
            state <= bau_pkg::BAU_ST_IDLE;
          end
        end
        default: begin
          state <= bau_pkg::BAU_ST_IDLE;
        end
      endcase
    end
  end

  // Sticky interrupt status; a new event wins over a clear.
  assign int_clr = (wr_fire && (wr_addr == `BAU_OFS_INT_STAT) && wr_strb[0]) ?
                   wr_data[1:0] : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat <= `BAU_RST_INT;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_evt;
    end
  end

  assign irq = |(int_stat & int_mask);

endmodule : bau_top

// ===== hdl/bau_params.svh
/*
  Constants of the binary arithmetic unit: register byte offsets, field
  positions, reset values and timing counts.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef BAU_PARAMS_SVH
`define BAU_PARAMS_SVH

`define BAU_OFS_CTRL      8'h00
`define BAU_OFS_FLAGS     8'h04
`define BAU_OFS_OPND0     8'h10
`define BAU_OFS_OPND3     8'h1C
`define BAU_OFS_RES0      8'h20
`define BAU_OFS_RES3      8'h2C
`define BAU_OFS_PTR0      8'h30
`define BAU_OFS_PTR2      8'h38
`define BAU_OFS_INT_STAT  8'h40
`define BAU_OFS_INT_MASK  8'h44

`define BAU_CTRL_OP_LSB   0
`define BAU_CTRL_OP_MSB   2
`define BAU_CTRL_EXEC     3
`define BAU_CTRL_START    4
`define BAU_CTRL_BUSY     5

`define BAU_FLAG_FAULT    0
`define BAU_FLAG_ZERO     1
`define BAU_FLAG_CARRY    2
`define BAU_FLAG_OVF      3
`define BAU_FLAG_UNF      4

`define BAU_INT_DONE      0
`define BAU_INT_FAULT     1

`define BAU_PTR_INDIRECT  16
`define BAU_DM_LIMIT      16'h1999

`define BAU_RST_WORD      16'h0000
`define BAU_RST_PTR       17'h00000
`define BAU_RST_INT       2'h0
`define BAU_DIV_STEPS     5'h10

`define BAU_RESP_OKAY     2'h0
`define BAU_RESP_SLVERR   2'h2

`endif

// ===== hdl/bau_pkg.sv
/*
  Types of the binary arithmetic unit: operation codes, sequencer states
  and the packed flag set.
  Assumes nothing of its surroundings.
*/
package bau_pkg;

  typedef enum logic [2:0] {
    BAU_OP_DIV   = 3'h0,
    BAU_OP_ADD   = 3'h1,
    BAU_OP_SUB   = 3'h2,
    BAU_OP_MUL16 = 3'h3,
    BAU_OP_MUL32 = 3'h4
  } bau_op_e;

  typedef enum logic [1:0] {
    BAU_ST_IDLE = 2'b01,
    BAU_ST_DIV  = 2'b10
  } bau_state_e;

  typedef struct packed {
    logic underflow_flag;
    logic overflow_flag;
    logic carry_flag;
    logic zero_flag;
    logic fault_flag;
  } bau_flags_s;

endpackage : bau_pkg

// ===== hdl/bau_ptr_check.sv
/*
  Checks one indirect data memory pointer for BCD digits and for the
  data memory area boundary.
  Assumes the pointer is stable while it is checked; purely combinational.
*/
`timescale 1ns/1ps
`include "bau_params.svh"

module bau_ptr_check (
  // Pointer under test
  input  wire logic [15:0] ptr_value,
  input  wire logic        indirect,
  // Verdict
  output logic             bad
);

  logic digit_bad;

  always_comb begin
    digit_bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (ptr_value[i*4 +: 4] > 4'h9) begin
        digit_bad = 1'b1;
      end
    end
    bad = indirect && (digit_bad || (ptr_value > `BAU_DM_LIMIT));
  end

endmodule : bau_ptr_check

// ===== hdl/bau_divider.sv
/*
  Sixteen-step restoring divider for unsigned 16-bit words.
  Assumes a non-zero divisor and that start only comes while idle.
*/
`timescale 1ns/1ps
`include "bau_params.svh"

module bau_divider (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Request
  input  wire logic        start,
  input  wire logic [15:0] dividend,
  input  wire logic [15:0] divisor,
  // Answer
  output logic             done,
  output logic [15:0]      quotient,
  output logic [15:0]      remainder
);

  logic [4:0]  count;
  logic [15:0] dvs;
  logic [16:0] partial;
  logic [16:0] diff;

  assign partial = {remainder, quotient[15]};
  assign diff    = partial - {1'b0, dvs};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count     <= 5'h00;
      dvs       <= `BAU_RST_WORD;
      quotient  <= `BAU_RST_WORD;
      remainder <= `BAU_RST_WORD;
      done      <= 1'b0;
    end else begin
      done <= (count == 5'h01);
      if (start) begin
        count     <= `BAU_DIV_STEPS;
        dvs       <= divisor;
        quotient  <= dividend;
        remainder <= `BAU_RST_WORD;
      end else if (count != 5'h00) begin
        count     <= count - 5'h01;
        remainder <= diff[16] ? partial[15:0] : diff[15:0];
        quotient  <= {quotient[14:0], ~diff[16]};
      end
    end
  end

endmodule : bau_divider

// ===== test/bau_top_props.sv
/*
  Concurrent checks on the ports of the binary arithmetic unit.
  Assumes one clock aclk and the synchronous active-low reset aresetn.
*/
`timescale 1ns/1ps
`include "bau_params.svh"

module bau_top_props (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Bus handshakes
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  // Status
  input wire bau_pkg::bau_flags_s flags,
  input wire logic                irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [4:0] since_wr;

  // Counts cycles since the last accepted write address.
  always_ff @(posedge aclk) begin
    if (!aresetn) since_wr <= 5'h1F;
    else if (s_axi_awvalid && s_axi_awready) since_wr <= 5'h00;
    else if (since_wr != 5'h1F) since_wr <= since_wr + 5'h01;
  end

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early.");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early.");

  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("Late write answer.");

  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("Late read answer.");

  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("Read not refused.");

  property p_aw_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("Write not refused.");

  property p_flags_quiet;
    !$stable(flags) |-> since_wr <= 5'd24;
  endproperty
  a_flags_quiet: assert property (p_flags_quiet)
    else $error("Flags changed without a command.");

  property p_ovf_excl;
    !(flags.overflow_flag && flags.underflow_flag);
  endproperty
  a_ovf_excl: assert property (p_ovf_excl)
    else $error("Overflow and underflow both set.");

  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `BAU_RESP_SLVERR);
  c_irq:    cover property (irq);
  c_fault:  cover property (flags.fault_flag);
endmodule : bau_top_props

bind bau_top bau_top_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .flags(flags), .irq(irq));

// ===== test/binary_arith_unit_test.sv
/*
  Self-checking bench of the binary arithmetic unit over AXI4-Lite.
  Assumes the bau_top register map and a 25 MHz clock.
*/
`timescale 1ns/1ps
`include "bau_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end

module binary_arith_unit_test;
  localparam logic signed [33:0] HI = 34'sh07FFFFFFF;
  localparam logic signed [33:0] LO = -34'sh080000000;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, ist = 2'h0;
  bau_pkg::bau_flags_s flags;
  int          errors = 0, check_count = 0;
  logic [33:0] exp_q[$];
  logic [15:0] res[4] = '{default: 16'h0};
  logic [4:0]  flg = 5'h0;
  logic        pf = 1'b0;

  always #20 aclk = ~aclk;

  bau_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flags(flags), .irq(irq));

  task complete_run;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  // Compares every read answer with the oldest expectation.
  always @(posedge aclk) begin
    logic [33:0] e;
    if (rvalid && rready) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~{rresp, rdata};
      `CHK({rresp, rdata}, e)
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    bit ao, wo;
    ao = 1;
    wo = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50 && (ao || wo); i++) begin
      @(posedge aclk);
      if (ao && awready) begin
        ao = 0;
        awvalid <= 1'b0;
      end
      if (wo && wready) begin
        wo = 0;
        wvalid <= 1'b0;
      end
    end
    repeat ($urandom_range(4)) @(posedge aclk);
    if (i < 50) bready <= 1'b1;
    for (i = i; i < 50; i++) begin
      @(posedge aclk);
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i >= 50) begin
      errors++;
      complete_run();
    end
    `CHK(bresp, `BAU_RESP_OKAY)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int i;
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) break;
    end
    arvalid <= 1'b0;
    repeat ($urandom_range(4)) @(posedge aclk);
    if (i < 50) rready <= 1'b1;
    for (i = i; i < 50; i++) begin
      @(posedge aclk);
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (i >= 50) begin
      errors++;
      complete_run();
    end
  endtask : rd

  task automatic setc(input logic c);
    wr(`BAU_OFS_FLAGS, {29'h0, c, 2'h0});
    flg[2] = c;
  endtask : setc

  task automatic op(input logic [2:0] o, input logic e, input logic [63:0] v);
    logic [32:0] s;
    logic signed [33:0] t, ta, tb, tc;
    logic [63:0] p;
    int k;
    for (k = 0; k < 4; k++) begin
      wr(`BAU_OFS_OPND0 + 8'(4 * k), {16'h0, v[16*k +: 16]});
    end
    wr(`BAU_OFS_CTRL, {27'h0, 1'b1, e, o});
    repeat (20) @(posedge aclk);
    ta = {{2{v[31]}}, v[31:0]};
    tb = {{2{v[63]}}, v[63:32]};
    tc = {33'h0, flg[2]};
    s = (o == 3'h2) ? {1'b0, v[31:0]} - v[63:32] - flg[2]
                    : {1'b0, v[31:0]} + v[63:32] + flg[2];
    t = (o == 3'h2) ? ta - tb - tc : ta + tb + tc;
    p = (o == 3'h3) ? {{16{v[15]}}, v[15:0]} * {{16{v[47]}}, v[47:32]}
                    : {{32{v[31]}}, v[31:0]} * {{32{v[63]}}, v[63:32]};
    if (e && o <= 3'h4) begin
      ist[0] = 1'b1;
      flg[0] = pf || (o == 3'h0 && v[47:32] == 16'h0);
      if (!flg[0]) begin
        case (o)
          3'h0: begin
            res[0] = v[15:0] / v[47:32];
            res[1] = v[15:0] % v[47:32];
            flg[1] = (res[0] == 16'h0);
          end
          3'h1, 3'h2: begin
            {res[1], res[0]} = s[31:0];
            flg[4:1] = {t < LO, t > HI, s[32], s[31:0] == 32'h0};
          end
          3'h3: begin
            {res[1], res[0]} = p[31:0];
            flg[1] = (p[31:0] == 32'h0);
          end
          default: begin
            {res[3], res[2], res[1], res[0]} = p;
            flg[1] = (p == 64'h0);
          end
        endcase
      end
      if (flg[0]) ist[1] = 1'b1;
    end
    `CHK(flags, flg)
    for (k = 0; k < 4; k++) begin
      rd(`BAU_OFS_RES0 + 8'(4 * k), {18'h0, res[k]});
    end
    rd(`BAU_OFS_FLAGS, {29'h0, flg});
    rd(`BAU_OFS_CTRL, {30'h0, e, o});
  endtask : op

  initial begin
    logic [15:0] pv[3];
    int n;
    pv = '{16'h00A0, 16'h2000, 16'h1999};
    void'($urandom(48));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`BAU_OFS_FLAGS, 34'h0);
    rd(8'h50, {`BAU_RESP_SLVERR, 32'h0});
    for (n = 0; n < 15; n++) begin
      setc(1'($urandom_range(1)));
      op(3'(n % 5), 1'b1, {$urandom, $urandom});
    end
    setc(1'b0);
    op(3'h0, 1'b1, 64'h0000_0000_0000_1234);
    op(3'h1, 1'b1, 64'h0000_0001_7FFF_FFFF);
    op(3'h2, 1'b1, 64'h0000_0001_8000_0000);
    op(3'h1, 1'b1, 64'h0000_0001_FFFF_FFFF);
    op(3'h2, 1'b1, 64'h0000_0002_0000_0001);
    op(3'h3, 1'b1, 64'h0000_1234_0000_0000);
    op(3'h4, 1'b1, 64'hFFFF_FFFF_0000_0003);
    op(3'h0, 1'b1, 64'h0000_0007_0000_0005);
    op(3'h1, 1'b0, {$urandom, $urandom});
    op(3'h5, 1'b1, {$urandom, $urandom});
    for (n = 0; n < 3; n++) begin
      pf = (n < 2);
      wr(`BAU_OFS_PTR0 + 8'(4 * n), {15'h0, 1'b1, pv[n]});
      op(3'h1, 1'b1, {$urandom, $urandom});
      wr(`BAU_OFS_PTR0 + 8'(4 * n), 32'h0);
    end
    `CHK(irq, 1'b0)
    wr(`BAU_OFS_INT_MASK, 32'h2);
    @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(`BAU_OFS_INT_STAT, 32'h2);
    ist[1] = 1'b0;
    @(posedge aclk);
    `CHK(irq, 1'b0)
    rd(`BAU_OFS_INT_STAT, {32'h0, ist});
    rd(`BAU_OFS_INT_MASK, {32'h0, 2'h2});
    complete_run();
  end
endmodule : binary_arith_unit_test
